// ===== shared/adapt_eq_consts.svh
/*
  Offsets, field positions, reset values and timing counts of the adaptive
  cable equalizer control block.
  Assumes a 20 MHz core clock and an 8-bit register access port.
*/
`ifndef ADAPT_EQ_CONSTS_SVH
`define ADAPT_EQ_CONSTS_SVH

// Register offsets
`define OFS_RESERVED_D1 8'hd1
`define OFS_ADAPT_CONTROL 8'hd2
`define OFS_ADAPT_SETTING_STATUS 8'hd3
`define OFS_MANUAL_SETTING_BYPASS 8'hd4
`define OFS_ADAPT_LIMITS 8'hd5
`define OFS_RESERVED_D6 8'hd6
`define OFS_RESERVED_D7 8'hd7

// Reset values
`define RST_RESERVED_D1 8'h43
`define RST_WAIT_CODE 3'h4
`define RST_FIRST_LOCK 1'h1
`define RST_FLOOR_EN 1'h1
`define RST_HIGH_BITS 3'h3
`define RST_LOCK_WAITS 1'h0
`define RST_LOW_BITS 3'h0
`define RST_ADAPT_DISABLE 1'h0
`define RST_FLOOR_VALUE 4'h2
`define RST_UPPER_LIMIT 4'hf

// Field positions
`define FLD_WAIT_HI 7
`define FLD_WAIT_LO 5
`define FLD_FIRST_LOCK 4
`define FLD_RESTART 3
`define FLD_FLOOR_EN 2
`define FLD_LOCK_WAITS 4
`define FLD_ADAPT_DISABLE 0

// Shortest wait time, each code doubles it
`define WAIT_BASE_NS 164000
`define CLOCK_PERIOD_NS 50
`define WAIT_BASE_CYCLES (`WAIT_BASE_NS / `CLOCK_PERIOD_NS)

`endif

// ===== shared/adapt_eq_pkg.sv
/*
  Types of the adaptive cable equalizer control block.
  Assumes the constants header is compiled alongside.
*/
package adapt_eq_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT,
    ST_DONE
  } adapt_state_e;
endpackage : adapt_eq_pkg

// ===== verilog/lock_wait_timer.sv
/*
  Lock wait timer: counts the selected doubling wait time and pulses on expiry.
  Assumes a 20 MHz clock; start restarts the count.
*/
`include "adapt_eq_consts.svh"

module lock_wait_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic start,
  input wire logic run,
  input wire logic [2:0] code,
  output logic expired
);
  typedef struct packed {
    logic [22:0] count;
    logic expired;
  } timer_s;

  timer_s st_r;
  timer_s st_nxt;
  logic [22:0] limit;

  // Base count shifted by code; code 7 gives 20.992 ms, 21.0 ms rounded up
  assign limit = 23'(`WAIT_BASE_CYCLES) << code;

  ////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.expired = 1'b0;
    if (start || !run) begin
      st_nxt.count = 23'h000000;
    end else if (st_r.count >= limit - 23'h000001) begin
      st_nxt.count = 23'h000000;
      st_nxt.expired = 1'b1;
    end else begin
      st_nxt.count = st_r.count + 23'h000001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '0;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign expired = st_r.expired;
endmodule : lock_wait_timer

// ===== verilog/adaptive_eq_control.sv
/*
  Adaptive cable equalizer control for two receive ports, with byte-wide
  register access and a port select.
  Assumes the register access port is driven from CLOCK logic; lock detector
  input comes from another domain and is synchronised here.
*/
`include "adapt_eq_consts.svh"

// Functional notes
// - Three-bit code picks doubling lock wait from 164 us to 21.0 ms, reset 100.
// - No lock within the wait time advances gain one step, then waits again.
// - First-lock bit set restarts adaptation at zero on initial lock.
// - Restart bit restarts adaptation from initial value and clears itself.
// - Floor enable set starts adaptation at floor, else at zero.
// - Four-bit floor field, reset 2, gives the starting gain.
// - Upper nibble maximum bounds the gain adaptation may reach.
// - Bypass bit disables adaptation when one, enables it when zero.
// - Bypassed setting is stage-one field high bits, stage-two field low bits.
// - Lock-mode set reports lock only after adaptation completes.
// - Each port has its own registers, chosen by the port-select value.
module adaptive_eq_control (
  input wire logic CLOCK,
  input wire logic RESET_N,
  input wire logic CE,
  input wire logic PORT_SEL,
  input wire logic [7:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  input wire logic [1:0] RX_LOCK_RAW,
  output logic [11:0] EQ_SETTING,
  output logic [1:0] RX_LOCK
);
  localparam int NP = 2;

  typedef struct packed {
    logic [2:0] wait_code;
    logic first_lock;
    logic restart;
    logic floor_en;
    logic [2:0] high_bits;
    logic lock_waits;
    logic [2:0] low_bits;
    logic disable_adapt;
    logic [3:0] upper_limit;
    logic [3:0] floor_value;
    logic [7:0] rsv_d6;
    logic [7:0] rsv_d7;
    logic [5:0] gain;
    logic done;
    logic lock_seen;
    logic [1:0] lock_sync;
    adapt_eq_pkg::adapt_state_e state;
  } port_s;

  typedef struct packed {
    port_s [NP-1:0] port;
    logic [7:0] rdata;
    logic [11:0] eq_out;
    logic [1:0] lock_out;
  } top_s;

  top_s st_r;
  top_s st_nxt;
  logic [NP-1:0] expired;
  logic [NP-1:0] tmr_start;
  logic [NP-1:0] tmr_run;
  logic [1:0] lock_meta_r;

  // First synchroniser stage is read only by the second stage
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_meta_r <= 2'h0;
    end else if (CE) begin
      lock_meta_r <= RX_LOCK_RAW;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-port wait timers
  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_tmr
      assign tmr_run[g] = (st_r.port[g].state == adapt_eq_pkg::ST_WAIT);
      lock_wait_timer u_tmr (
        .clk(CLOCK),
        .rst_n(RESET_N),
        .ce(CE),
        .start(tmr_start[g]),
        .run(tmr_run[g]),
        .code(st_r.port[g].wait_code),
        .expired(expired[g])
      );
    end
  endgenerate

  function automatic logic [5:0] start_gain(input port_s p);
    start_gain = p.floor_en ? {2'h0, p.floor_value} : 6'h00;
  endfunction : start_gain

  ////////////////////////////////////////////////////////////////
  // Register access, adaptation and lock reporting
  always_comb begin
    logic sel;
    logic lk;
    logic lk_old;
    st_nxt = st_r;
    tmr_start = '0;
    sel = 1'b0;
    lk = 1'b0;
    lk_old = 1'b0;
    for (int i = 0; i < NP; i++) begin
      sel = (PORT_SEL == i[0]);
      st_nxt.port[i].lock_sync = {st_r.port[i].lock_sync[0], lock_meta_r[i]};
      lk = st_r.port[i].lock_sync[1];
      lk_old = st_r.port[i].lock_seen;
      st_nxt.port[i].lock_seen = lk;
      st_nxt.port[i].restart = 1'b0; // self clearing
      // Adaptation state machine
      unique case (st_r.port[i].state)
        adapt_eq_pkg::ST_IDLE: begin
          st_nxt.port[i].gain = start_gain(st_r.port[i]);
          st_nxt.port[i].done = 1'b0;
          st_nxt.port[i].state = adapt_eq_pkg::ST_WAIT;
          tmr_start[i] = 1'b1;
        end
        adapt_eq_pkg::ST_WAIT: begin
          if (lk) begin
            st_nxt.port[i].done = 1'b1;
            st_nxt.port[i].state = adapt_eq_pkg::ST_DONE;
          end else if (expired[i]) begin
            // Wrap to start when the limit is reached, so a dead cable keeps sweeping
            if (st_r.port[i].gain >= {2'h0, st_r.port[i].upper_limit}) begin
              st_nxt.port[i].gain = start_gain(st_r.port[i]);
            end else begin
              st_nxt.port[i].gain = st_r.port[i].gain + 6'h01;
            end
          end
        end
        adapt_eq_pkg::ST_DONE: begin
          if (!lk) begin
            st_nxt.port[i].done = 1'b0;
            st_nxt.port[i].state = adapt_eq_pkg::ST_WAIT;
            tmr_start[i] = 1'b1;
          end
        end
      endcase
      // Initial lock restarts at zero when first-lock option is set
      if (lk && !lk_old && st_r.port[i].first_lock && !st_r.port[i].done) begin
        st_nxt.port[i].gain = 6'h00;
        st_nxt.port[i].done = 1'b1;
        st_nxt.port[i].state = adapt_eq_pkg::ST_DONE;
      end
      // Register writes to the selected port copy
      if (REG_WR && sel) begin
        unique case (REG_ADDR)
          `OFS_ADAPT_CONTROL: begin
            st_nxt.port[i].wait_code = REG_WDATA[`FLD_WAIT_HI:`FLD_WAIT_LO];
            st_nxt.port[i].first_lock = REG_WDATA[`FLD_FIRST_LOCK];
            st_nxt.port[i].floor_en = REG_WDATA[`FLD_FLOOR_EN];
            if (REG_WDATA[`FLD_RESTART]) begin
              st_nxt.port[i].restart = 1'b1;
              st_nxt.port[i].state = adapt_eq_pkg::ST_IDLE;
            end
          end
          `OFS_MANUAL_SETTING_BYPASS: begin
            st_nxt.port[i].high_bits = REG_WDATA[7:5];
            st_nxt.port[i].lock_waits = REG_WDATA[`FLD_LOCK_WAITS];
            st_nxt.port[i].low_bits = REG_WDATA[3:1];
            st_nxt.port[i].disable_adapt = REG_WDATA[`FLD_ADAPT_DISABLE];
          end
          `OFS_ADAPT_LIMITS: begin
            st_nxt.port[i].upper_limit = REG_WDATA[7:4];
            st_nxt.port[i].floor_value = REG_WDATA[3:0];
          end
          `OFS_RESERVED_D6: st_nxt.port[i].rsv_d6 = REG_WDATA;
          `OFS_RESERVED_D7: st_nxt.port[i].rsv_d7 = REG_WDATA;
          default: ;
        endcase
      end
      // Bypass holds the sweep idle and forces the programmed setting
      if (st_r.port[i].disable_adapt) begin
        st_nxt.port[i].state = adapt_eq_pkg::ST_IDLE;
        st_nxt.port[i].done = 1'b0;
        st_nxt.port[i].gain = {st_r.port[i].high_bits, st_r.port[i].low_bits};
      end
      st_nxt.eq_out[6*i +: 6] = st_r.port[i].gain;
      st_nxt.lock_out[i] = st_r.port[i].lock_waits ? (lk && st_r.port[i].done) : lk;
    end
    // Read data from the selected port copy
    if (REG_RD) begin
      unique case (REG_ADDR)
        `OFS_RESERVED_D1: st_nxt.rdata = `RST_RESERVED_D1;
        `OFS_ADAPT_CONTROL: st_nxt.rdata = {st_r.port[PORT_SEL].wait_code, st_r.port[PORT_SEL].first_lock,
                                            st_r.port[PORT_SEL].restart, st_r.port[PORT_SEL].floor_en, 2'h0};
        `OFS_ADAPT_SETTING_STATUS: st_nxt.rdata = {2'h0, st_r.port[PORT_SEL].gain};
        `OFS_MANUAL_SETTING_BYPASS: st_nxt.rdata = {st_r.port[PORT_SEL].high_bits, st_r.port[PORT_SEL].lock_waits,
                                                    st_r.port[PORT_SEL].low_bits, st_r.port[PORT_SEL].disable_adapt};
        `OFS_ADAPT_LIMITS: st_nxt.rdata = {st_r.port[PORT_SEL].upper_limit, st_r.port[PORT_SEL].floor_value};
        `OFS_RESERVED_D6: st_nxt.rdata = st_r.port[PORT_SEL].rsv_d6;
        `OFS_RESERVED_D7: st_nxt.rdata = st_r.port[PORT_SEL].rsv_d7;
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // Register the whole state; gain resets to zero, then IDLE loads the start gain on the first enabled cycle
  always_ff @(posedge CLOCK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_r <= '0;
      for (int i = 0; i < NP; i++) begin
        st_r.port[i].wait_code <= `RST_WAIT_CODE;
        st_r.port[i].first_lock <= `RST_FIRST_LOCK;
        st_r.port[i].floor_en <= `RST_FLOOR_EN;
        st_r.port[i].high_bits <= `RST_HIGH_BITS;
        st_r.port[i].lock_waits <= `RST_LOCK_WAITS;
        st_r.port[i].low_bits <= `RST_LOW_BITS;
        st_r.port[i].disable_adapt <= `RST_ADAPT_DISABLE;
        st_r.port[i].upper_limit <= `RST_UPPER_LIMIT;
        st_r.port[i].floor_value <= `RST_FLOOR_VALUE;
        st_r.port[i].state <= adapt_eq_pkg::ST_IDLE;
      end
    end else if (CE) begin
      st_r <= st_nxt;
    end
  end

  assign REG_RDATA = st_r.rdata;
  assign EQ_SETTING = st_r.eq_out;
  assign RX_LOCK = st_r.lock_out;

  ////////////////////////////////////////////////////////////////
  // Checks
  // Two enabled cycles of bypass in a row
  sequence s_bypass_on;
    CE && st_r.port[0].disable_adapt ##1 CE && st_r.port[0].disable_adapt;
  endsequence

  property p_bypass_setting;
    @(posedge CLOCK) disable iff (!RESET_N)
      s_bypass_on |-> st_r.port[0].gain == {$past(st_r.port[0].high_bits), $past(st_r.port[0].low_bits)};
  endproperty
  a_bypass_setting: assert property (p_bypass_setting) else $error("bypass setting not applied");

  property p_restart_clears;
    @(posedge CLOCK) disable iff (!RESET_N)
      CE && st_r.port[0].restart ##1 CE |-> !st_r.port[0].restart;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("restart bit stuck");

  property p_gain_limit;
    @(posedge CLOCK) disable iff (!RESET_N)
      CE && !st_r.port[0].disable_adapt && expired[0] && st_r.port[0].state == adapt_eq_pkg::ST_WAIT
        && !st_r.port[0].lock_sync[1] && st_r.port[0].gain < {2'h0, st_r.port[0].upper_limit}
        && !(REG_WR && !PORT_SEL)
      |=> st_r.port[0].gain == $past(st_r.port[0].gain) + 6'h01;
  endproperty
  a_gain_limit: assert property (p_gain_limit) else $error("gain did not step");

  property p_lock_mode;
    @(posedge CLOCK) disable iff (!RESET_N)
      CE && st_r.port[0].lock_waits && !st_r.port[0].done ##1 CE |-> !RX_LOCK[0];
  endproperty
  a_lock_mode: assert property (p_lock_mode) else $error("lock reported before adaptation");

  // Restart or release from bypass loads floor or zero; lock edge excluded
  property p_start_gain;
    @(posedge CLOCK) disable iff (!RESET_N)
      CE && st_r.port[0].state == adapt_eq_pkg::ST_IDLE && !st_r.port[0].disable_adapt
        && !st_r.port[0].lock_sync[1] && !(REG_WR && !PORT_SEL)
      |=> st_r.port[0].gain == ($past(st_r.port[0].floor_en) ? {2'h0, $past(st_r.port[0].floor_value)} : 6'h00);
  endproperty
  a_start_gain: assert property (p_start_gain) else $error("start gain not loaded");

  // Initial lock with the first-lock option set lands at setting zero
  property p_first_lock_zero;
    @(posedge CLOCK) disable iff (!RESET_N)
      CE && st_r.port[0].lock_sync[1] && !st_r.port[0].lock_seen && st_r.port[0].first_lock
        && !st_r.port[0].done && !st_r.port[0].disable_adapt && !(REG_WR && !PORT_SEL)
      |=> st_r.port[0].gain == 6'h00 && st_r.port[0].done;
  endproperty
  a_first_lock_zero: assert property (p_first_lock_zero) else $error("first lock kept gain");
endmodule : adaptive_eq_control

// ===== tb/lock_source.sv
/*
  Stand-in for the receiver lock detectors of both receive ports.
  Assumes the bench asks for lock per port; the output is not tied to the core clock.
*/
module lock_source (
  input wire logic [1:0] lock_req,
  output logic [1:0] lock_raw
);
  timeunit 1ns;
  timeprecision 100ps;

  ////////////////////////////////////////////////////////////////////////////
  // Odd delay keeps lock edges away from the core clock, as a real detector would
  // One process drives the output so it starts unlocked, never unknown
  initial begin
    lock_raw = 2'b00;
    forever begin
      @(lock_req);
      lock_raw <= #7 lock_req; // Each port keeps its own lock
    end
  end
endmodule : lock_source

// ===== tb/testbench.sv
/*
  Self-checking bench for the adaptive equalizer control block.
  Assumes the design and the lock stand-in are compiled first; runs about 30k cycles.
*/
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic CLOCK = 1'b0;
  logic RESET_N = 1'b0;
  logic CE = 1'b1;
  logic PORT_SEL = 1'b0;
  logic [7:0] REG_ADDR = 8'h00;
  logic REG_WR = 1'b0;
  logic [7:0] REG_WDATA = 8'h00;
  logic REG_RD = 1'b0;
  logic [7:0] REG_RDATA;
  logic [1:0] RX_LOCK_RAW;
  logic [11:0] EQ_SETTING;
  logic [1:0] RX_LOCK;
  logic [1:0] lock_req = 2'b00;
  int fails = 0;
  int checks_done = 0;
  logic [7:0] mr [2][8];
  int eg [2];
  logic [7:0] seed = 8'h63;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, lock source and design
  always #25 CLOCK = ~CLOCK;
  lock_source src (.lock_req(lock_req), .lock_raw(RX_LOCK_RAW));
  adaptive_eq_control DUT (.CLOCK(CLOCK), .RESET_N(RESET_N), .CE(CE), .PORT_SEL(PORT_SEL),
    .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_WDATA(REG_WDATA), .REG_RD(REG_RD),
    .REG_RDATA(REG_RDATA), .RX_LOCK_RAW(RX_LOCK_RAW), .EQ_SETTING(EQ_SETTING), .RX_LOCK(RX_LOCK));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic close_out;
    $display("Counts: %0d checks, %0d mismatches", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr

  function automatic logic [7:0] gain_of(input logic p);
    return p ? {2'b00, EQ_SETTING[11:6]} : {2'b00, EQ_SETTING[5:0]};
  endfunction : gain_of

  task automatic gchk(input logic p);
    chk($sformatf("gain port %0d", p), 8'(eg[p]), gain_of(p));
  endtask : gchk

  // Model keeps only what software can change; restart bit never reads back set
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    @(posedge CLOCK);
    PORT_SEL <= p;
    REG_ADDR <= a;
    REG_WDATA <= d;
    REG_WR <= 1'b1;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
    if (a == 8'hd2) begin
      mr[p][2] = d & 8'hf4;
    end else if (a inside {8'hd4, 8'hd5, 8'hd6, 8'hd7}) begin
      mr[p][a[2:0]] = d;
    end
  endtask : wr

  task automatic rd(input logic p, input logic [7:0] a);
    logic [7:0] e;
    @(posedge CLOCK);
    PORT_SEL <= p;
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    @(posedge CLOCK);
    REG_RD <= 1'b0;
    @(posedge CLOCK);
    #1;
    if (a[7:3] != 5'h1a || a[2:0] == 3'd0) begin
      e = 8'h00;
    end else if (a[2:0] == 3'd3) begin
      e = 8'(eg[p]);
    end else begin
      e = mr[p][a[2:0]];
    end
    chk($sformatf("reg %h port %0d", a, p), e, REG_RDATA);
  endtask : rd

  // Bounded wait for a gain and a reported lock on one port
  task automatic settle(input logic p, input logic [5:0] g, input logic l);
    int n;
    n = 0;
    while (gain_of(p) !== {2'b00, g} || RX_LOCK[p] !== l) begin
      @(posedge CLOCK);
      #1;
      n++;
      if (n > 20) begin
        fails++;
        $display("ERROR settle port %0d expected %h seen %h", p, g, gain_of(p));
        close_out();
      end
    end
    checks_done++;
    eg[p] = g;
  endtask : settle

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    mr[0] = '{8'h00, 8'h43, 8'h94, 8'h00, 8'h60, 8'hf2, 8'h00, 8'h00};
    mr[1] = mr[0];
    eg = '{2, 2};
    repeat (3) @(posedge CLOCK);
    chk("gain in reset", 8'h00, gain_of(1'b0));
    @(posedge CLOCK);
    RESET_N <= 1'b1;
    // Reset values, unmapped places, ignored writes and per-port copies
    for (int pass = 0; pass < 2; pass++) begin
      for (int k = 0; k < 2; k++) begin
        for (int a = 0; a < 9; a++) begin
          rd(k[0], 8'hd0 + 8'(a));
        end
        if (pass == 0) begin
          wr(k[0], 8'hd1, 8'hff);
          wr(k[0], 8'hd3, 8'hff);
          seed = lfsr(seed);
          wr(k[0], 8'hd6, seed);
          seed = lfsr(seed);
          wr(k[0], 8'hd7, seed);
        end
      end
    end
    // Bypass: setting from the two fields, lock held back while not adapted
    wr(1'b0, 8'hd4, 8'hbd);
    lock_req <= 2'b01;
    repeat (20) @(posedge CLOCK);
    eg[0] = 8'h2e;
    gchk(1'b0);
    gchk(1'b1);
    chk("bypass lock", 8'h00, {7'd0, RX_LOCK[0]});
    lock_req <= 2'b00;
    wr(1'b0, 8'hd4, 8'h60);
    // Stepping from the floor with the shortest wait, wrapping at the maximum
    wr(1'b0, 8'hd5, 8'h31); // Maximum kept above floor
    wr(1'b0, 8'hd2, 8'h1c);
    eg[0] = 1;
    rd(1'b0, 8'hd2);
    repeat (1637) @(posedge CLOCK);
    for (int s = 0; s < 4; s++) begin
      eg[0] = (s == 3) ? 1 : 1 + s;
      gchk(1'b0);
      rd(1'b0, 8'hd3);
      repeat (3277) @(posedge CLOCK);
    end
    // Floor off: start from zero
    wr(1'b0, 8'hd2, 8'h18);
    eg[0] = 0;
    repeat (1640) @(posedge CLOCK);
    gchk(1'b0);
    // Clock enable low freezes the sweep, so the step comes one wait later
    CE <= 1'b0;
    repeat (3280) @(posedge CLOCK);
    CE <= 1'b1;
    gchk(1'b0);
    repeat (3280) @(posedge CLOCK);
    eg[0] = 1;
    gchk(1'b0);
    // First lock restarts at zero; lock follows the detector alone
    lock_req <= 2'b01;
    settle(1'b0, 6'h00, 1'b1);
    // Second port without first-lock restart keeps its gain
    wr(1'b1, 8'hd2, 8'h0c);
    repeat (1640) @(posedge CLOCK);
    lock_req <= 2'b11;
    settle(1'b1, 6'h02, 1'b1);
    repeat (3400) @(posedge CLOCK);
    gchk(1'b1);
    gchk(1'b0);
    close_out();
  end
endmodule : testbench
